/* File: mwbt_pkg.sv */
// Purpose: Shared constants and types for the master window bus translator
// Assumes: 200 MHz system clock, host cycle requests held until ready
// Notes:   All offsets, field positions and counts live here by name
package mwbt_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned HOST_LIMIT_NS   = 14800;  // Longest host cycle hold
  localparam int unsigned HOST_LIMIT_CYC  = (HOST_LIMIT_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned TMO_W           = 12;

  // Window geometry
  localparam int unsigned HADDR_W         = 24;
  localparam int unsigned WIN_OFS_W       = 16;
  localparam int unsigned WIN_BASE_W      = HADDR_W - WIN_OFS_W;
  localparam int unsigned PAGE_W          = 16;
  localparam int unsigned AM_W            = 5;
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned RADDR_W         = 32;

  // Window control register layout: enable in bit 0, base in [15:8], modifier in [28:24]
  localparam int unsigned CTRL_W          = 29;
  localparam int unsigned CTRL_EN_BIT     = 0;
  localparam int unsigned CTRL_BASE_LSB   = 8;
  localparam int unsigned CTRL_AM_LSB     = 24;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 29'h0000000;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 16'h0000;

  // Address modifier codes with known decoding
  localparam logic [AM_W-1:0] AM_A16_NPRIV = 5'h11;
  localparam logic [AM_W-1:0] AM_A24       = 5'h19;
  localparam logic [AM_W-1:0] AM_A32       = 5'h01;

  // Status bit positions
  localparam int unsigned STAT_W          = 2;
  localparam int unsigned STAT_DL_BIT     = 0;
  localparam int unsigned STAT_TO_BIT     = 1;

  typedef enum logic [1:0] {
    MWBT_SP_A16 = 2'b00,
    MWBT_SP_A24 = 2'b01,
    MWBT_SP_A32 = 2'b10
  } mwbt_space_t;

  typedef enum logic [1:0] {
    MWBT_ST_IDLE = 2'b00,
    MWBT_ST_BUSY = 2'b01,
    MWBT_ST_DONE = 2'b10
  } mwbt_state_t;

endpackage : mwbt_pkg

/* File: mwbt_xlate_if.sv */
// Purpose: Carries window settings from the register holder to the cycle engine
// Assumes: Single clock domain
// Notes:   Register side drives, engine side only reads
`timescale 1ns/100ps
interface mwbt_xlate_if;
  import mwbt_pkg::*;
  logic                  win_en;
  logic [WIN_BASE_W-1:0] win_base;
  logic [AM_W-1:0]       am;
  logic [PAGE_W-1:0]     page;
  mwbt_space_t           space;

  modport regs (output win_en, win_base, am, page, space);
  modport eng  (input  win_en, win_base, am, page, space);
endinterface : mwbt_xlate_if

/* File: mwbt_cfg_regs.sv */
// Purpose: Holds window control and page settings, decodes the target space
// Assumes: Writes come from the host register port in the system clock domain
// Notes:   Settings change only on write, never on access
`timescale 1ns/100ps
module mwbt_cfg_regs
  import mwbt_pkg::*;
(
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  // Write port
  input  wire logic                     i_ctrl_we,
  input  wire logic [CTRL_W-1:0]        i_ctrl_wdata,
  input  wire logic                     i_page_we,
  input  wire logic [PAGE_W-1:0]        i_page_wdata,
  // Settings out
  mwbt_xlate_if.regs                    cfg
);

  logic [CTRL_W-1:0] ctrl_q;
  logic [PAGE_W-1:0] page_q;

  // Space decode; bits [4:3] of 11 give mid, 10 with nonzero low bits short, all others long
  function automatic mwbt_space_t space_of(input logic [AM_W-1:0] am);
    if (am == AM_A16_NPRIV || am[4:3] == 2'h1 || am[4:3] == 2'h2) begin
      space_of = (am == AM_A16_NPRIV) ? MWBT_SP_A16 : MWBT_SP_A32;
    end else begin
      space_of = MWBT_SP_A32;
    end
    if (am == AM_A24 || am[4:3] == 2'h3) begin
      space_of = MWBT_SP_A24;
    end
    if (am == AM_A16_NPRIV || am[4:3] == 2'h2 && am[2:0] != 3'h0) begin
      space_of = MWBT_SP_A16;
    end
    if (am == AM_A32 || am[4:3] == 2'h0) begin
      space_of = MWBT_SP_A32;
    end
  endfunction : space_of

  // Control register, rewritable any time
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (i_ctrl_we) begin
      ctrl_q <= i_ctrl_wdata;
    end
  end

  // Page held until rewritten
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      page_q <= PAGE_RESET;
    end else if (i_page_we) begin
      page_q <= i_page_wdata;
    end
  end

  assign cfg.win_en   = ctrl_q[CTRL_EN_BIT];
  assign cfg.win_base = ctrl_q[CTRL_BASE_LSB +: WIN_BASE_W];
  assign cfg.am       = ctrl_q[CTRL_AM_LSB +: AM_W];
  assign cfg.page     = page_q;
  assign cfg.space    = space_of(ctrl_q[CTRL_AM_LSB +: AM_W]);

endmodule : mwbt_cfg_regs

/* File: mwbt_status.sv */
// Purpose: Sticky deadlock and timeout flags with optional interrupt request
// Assumes: Event pulses and clear strobes are on the system clock
// Notes:   A set in the clearing cycle wins so no event is lost
`timescale 1ns/100ps
module mwbt_status
  import mwbt_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // Events and software side
  input  wire logic [STAT_W-1:0] i_set,
  input  wire logic              i_clr,
  input  wire logic              i_rd,
  input  wire logic [STAT_W-1:0] i_irq_en,
  // Flags out
  output logic      [STAT_W-1:0] o_flags,
  output logic                   o_irq
);

  // Clear on write or on read, set has priority
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flags <= '0;
    end else if (i_clr || i_rd) begin
      o_flags <= i_set;
    end else begin
      o_flags <= o_flags | i_set;
    end
  end

  // Interrupt follows enabled flags
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |((o_flags | i_set) & i_irq_en);
    end
  end

endmodule : mwbt_status

/* File: mwbt_master_window.sv */
// Purpose: Translates host memory cycles in a 64 KB window into remote bus cycles
// Assumes: One clock; remote handshake inputs come from pins
// Notes:   Host waits on o_host_ready; early end is flagged by o_host_abort
//
// Operation
// - Every remote cycle carries the programmed five-bit address modifier.
// - The page value drives the upper remote address lines for long spaces.
// - The modifier may be rewritten any time and affects later cycles only.
// - With the window on, each host cycle inside it becomes a remote cycle.
// - Modifier 0x11 decodes as short space, 0x19 as mid space, 0x01 as long.
// - Short space uses only the 16-bit host offset as remote address.
// - Mid and long spaces join the page above the 16-bit host offset.
// - Page and modifier persist until software rewrites them.
// - A collision with an inbound remote master ends the host cycle early.
// - A deadlock end sets the deadlock flag and, when enabled, raises an interrupt.
// - A remote cycle that outlasts the host limit ends the host cycle early.
// - Only enabled-window hits on a 64 KB aligned base are answered.
// - A timeout end sets the timeout flag and, when enabled, raises an interrupt.
`timescale 1ns/100ps
module mwbt_master_window
  import mwbt_pkg::*;
(
  // Clock and reset
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_resetn,
  // Register writes
  input  wire logic                        i_ctrl_we,
  input  wire logic [mwbt_pkg::CTRL_W-1:0] i_ctrl_wdata,
  input  wire logic                        i_page_we,
  input  wire logic [mwbt_pkg::PAGE_W-1:0] i_page_wdata,
  // Status access
  input  wire logic                        i_stat_rd,
  input  wire logic                        i_stat_clr,
  input  wire logic [mwbt_pkg::STAT_W-1:0] i_irq_en,
  output logic      [mwbt_pkg::STAT_W-1:0] o_board_status_reg,
  output logic                             o_host_irq,
  // Host memory cycle
  input  wire logic                        i_host_req,
  input  wire logic                        i_host_wr,
  input  wire logic [mwbt_pkg::HADDR_W-1:0] i_host_addr,
  input  wire logic [mwbt_pkg::DATA_W-1:0] i_host_wdata,
  output logic                             o_host_ready,
  output logic                             o_host_abort,
  output logic [mwbt_pkg::DATA_W-1:0]      o_host_rdata,
  // Remote bus cycle
  output logic                             o_rem_cyc,
  output logic                             o_rem_wr,
  output logic [mwbt_pkg::AM_W-1:0]        o_rem_am,
  output logic [mwbt_pkg::RADDR_W-1:0]     o_rem_addr,
  output logic [mwbt_pkg::DATA_W-1:0]      o_rem_wdata,
  input  wire logic                        i_rem_ack,
  input  wire logic [mwbt_pkg::DATA_W-1:0] i_rem_rdata,
  input  wire logic                        i_rem_inbound
);
  import mwbt_pkg::*;

  logic               rst_s1_q, rst_s2_q;
  logic               ack_s1_q, ack_s2_q;
  logic               inb_s1_q, inb_s2_q;
  logic [DATA_W-1:0]  rdat_s1_q, rdat_s2_q;
  mwbt_state_t        state_q;
  logic [TMO_W-1:0]   tmo_q;
  logic [STAT_W-1:0]  ev_set;
  logic               hit;
  logic               rst_n;

  mwbt_xlate_if cfg ();

  // Reset release through two flops
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // Pin synchronisers for the remote side
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_s1_q  <= 1'b0;
      ack_s2_q  <= 1'b0;
      inb_s1_q  <= 1'b0;
      inb_s2_q  <= 1'b0;
      rdat_s1_q <= '0;
      rdat_s2_q <= '0;
    end else begin
      ack_s1_q  <= i_rem_ack;
      ack_s2_q  <= ack_s1_q;
      inb_s1_q  <= i_rem_inbound;
      inb_s2_q  <= inb_s1_q;
      rdat_s1_q <= i_rem_rdata;
      rdat_s2_q <= rdat_s1_q;
    end
  end

  mwbt_cfg_regs u_cfg (
    .i_clk        (i_sys_clk),
    .i_rst_n      (rst_n),
    .i_ctrl_we    (i_ctrl_we),
    .i_ctrl_wdata (i_ctrl_wdata),
    .i_page_we    (i_page_we),
    .i_page_wdata (i_page_wdata),
    .cfg          (cfg)
  );

  // Window hit: base compare on the upper bits keeps alignment
  assign hit = cfg.win_en && (i_host_addr[HADDR_W-1:WIN_OFS_W] == cfg.win_base);

  // Remote address from space, page and offset
  function automatic logic [RADDR_W-1:0] rem_addr(input mwbt_space_t sp,
                                                  input logic [PAGE_W-1:0] pg,
                                                  input logic [WIN_OFS_W-1:0] ofs);
    if (sp == MWBT_SP_A16) begin
      rem_addr = {16'h0000, ofs};
    end else begin
      rem_addr = {pg, ofs};
    end
  endfunction : rem_addr

  // Cycle engine; ack ends normally, inbound collision or limit ends early
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= MWBT_ST_IDLE;
      tmo_q        <= '0;
      o_rem_cyc    <= 1'b0;
      o_rem_wr     <= 1'b0;
      o_rem_am     <= '0;
      o_rem_addr   <= '0;
      o_rem_wdata  <= '0;
      o_host_ready <= 1'b0;
      o_host_abort <= 1'b0;
      o_host_rdata <= '0;
      ev_set       <= '0;
    end else begin
      o_host_ready <= 1'b0;
      o_host_abort <= 1'b0;
      ev_set       <= '0;
      case (state_q)
        MWBT_ST_IDLE: begin
          if (i_host_req && hit) begin
            o_rem_cyc   <= 1'b1;
            o_rem_wr    <= i_host_wr;
            o_rem_am    <= cfg.am;
            o_rem_addr  <= rem_addr(cfg.space, cfg.page,
                                    i_host_addr[WIN_OFS_W-1:0]);
            o_rem_wdata <= i_host_wdata;
            tmo_q       <= '0;
            state_q     <= MWBT_ST_BUSY;
          end
        end
        MWBT_ST_BUSY: begin
          tmo_q <= tmo_q + 1'b1;
          if (ack_s2_q) begin
            o_rem_cyc    <= 1'b0;
            o_host_ready <= 1'b1;
            o_host_rdata <= rdat_s2_q;
            state_q      <= MWBT_ST_DONE;
          end else if (inb_s2_q) begin
            o_rem_cyc                 <= 1'b0;
            o_host_ready              <= 1'b1;
            o_host_abort              <= 1'b1;
            ev_set[STAT_DL_BIT]       <= 1'b1;
            state_q                   <= MWBT_ST_DONE;
          end else if (tmo_q == TMO_W'(HOST_LIMIT_CYC - 1)) begin
            o_rem_cyc                 <= 1'b0;
            o_host_ready              <= 1'b1;
            o_host_abort              <= 1'b1;
            ev_set[STAT_TO_BIT]       <= 1'b1;
            state_q                   <= MWBT_ST_DONE;
          end
        end
        MWBT_ST_DONE: begin
          // Wait for the host to drop its request and the ack to fall
          if (!i_host_req && !ack_s2_q) begin
            state_q <= MWBT_ST_IDLE;
          end
        end
        default: begin
          state_q <= MWBT_ST_IDLE;
        end
      endcase
    end
  end

  mwbt_status u_stat (
    .i_clk    (i_sys_clk),
    .i_rst_n  (rst_n),
    .i_set    (ev_set),
    .i_clr    (i_stat_clr),
    .i_rd     (i_stat_rd),
    .i_irq_en (i_irq_en),
    .o_flags  (o_board_status_reg),
    .o_irq    (o_host_irq)
  );

endmodule : mwbt_master_window

/* File: mwbt_master_window_assertions.sv */
// Purpose: Port-level checks of the master window translator
// Assumes: One clock, active-low reset
// Notes:   Mirrors control and page writes to judge remote cycles
`timescale 1ns/100ps
module mwbt_master_window_assertions
  import mwbt_pkg::*;
(
  // Clock, reset and settings
  input wire logic                i_sys_clk,
  input wire logic                i_resetn,
  input wire logic                i_ctrl_we,
  input wire logic [CTRL_W-1:0]   i_ctrl_wdata,
  input wire logic                i_page_we,
  input wire logic [PAGE_W-1:0]   i_page_wdata,
  // Status
  input wire logic                i_stat_rd,
  input wire logic                i_stat_clr,
  input wire logic [STAT_W-1:0]   i_irq_en,
  input wire logic [STAT_W-1:0]   o_board_status_reg,
  input wire logic                o_host_irq,
  // Host and remote cycles
  input wire logic                i_host_req,
  input wire logic [HADDR_W-1:0]  i_host_addr,
  input wire logic                o_host_ready,
  input wire logic                o_host_abort,
  input wire logic                o_rem_cyc,
  input wire logic [AM_W-1:0]     o_rem_am,
  input wire logic [RADDR_W-1:0]  o_rem_addr
);
  logic [CTRL_W-1:0] ctrl_q;
  logic [PAGE_W-1:0] page_q;
  logic [11:0]       cnt_q;
  logic              hit;
  logic [AM_W-1:0]   am;

  // Shadow settings, updated only by writes
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q <= CTRL_RESET;
      page_q <= PAGE_RESET;
    end else begin
      if (i_ctrl_we) ctrl_q <= i_ctrl_wdata;
      if (i_page_we) page_q <= i_page_wdata;
    end
  end

  // Length of the running remote cycle
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) cnt_q <= 12'h000;
    else if (o_rem_cyc) cnt_q <= cnt_q + 12'h001;
    else if (i_host_req && !o_host_ready) cnt_q <= 12'h000;
  end

  assign am  = ctrl_q[CTRL_AM_LSB +: AM_W];
  assign hit = ctrl_q[CTRL_EN_BIT] && (i_host_addr[23:16] == ctrl_q[CTRL_BASE_LSB +: 8]);

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_start;
    $rose(o_rem_cyc);
  endsequence

  // Settings are taken at the edge before the cycle shows, hence the past values
  am_drive_a: assert property (s_start |-> o_rem_am == $past(am))
    else $error("modifier differs from setting");
  page_high_a: assert property ((s_start and ($past(am[4:3]) != 2'b10)) |->
    o_rem_addr[31:16] == $past(page_q))
    else $error("page not on upper lines");
  offset_low_a: assert property (s_start |-> o_rem_addr[15:0] == i_host_addr[15:0])
    else $error("offset not on lower lines");
  window_hit_a: assert property (s_start |-> $past(i_host_req && hit))
    else $error("remote cycle without window hit");
  miss_quiet_a: assert property (!o_rem_cyc && i_host_req && !hit |=> !o_rem_cyc)
    else $error("remote cycle on a miss");
  abort_ready_a: assert property (o_host_abort |-> o_host_ready)
    else $error("abort without cycle end");
  dl_flag_a: assert property (o_host_abort && cnt_q < 12'd2900 |=> o_board_status_reg[STAT_DL_BIT])
    else $error("deadlock flag not set");
  to_flag_a: assert property (o_host_abort && cnt_q > 12'd2900 |=> o_board_status_reg[STAT_TO_BIT])
    else $error("timeout flag not set");
  cycle_limit_a: assert property (cnt_q <= 12'd2962)
    else $error("remote cycle outlasts host limit");
  dl_sticky_a: assert property (o_board_status_reg[0] && !i_stat_rd && !i_stat_clr |=> o_board_status_reg[0])
    else $error("deadlock flag dropped");
  // Request tracks old flags or the new event, so a set shows with the flag
  irq_follow_a: assert property (1'b1 |=>
    o_host_irq == |(($past(o_board_status_reg) | o_board_status_reg) & $past(i_irq_en)))
    else $error("interrupt does not follow flags");
endmodule : mwbt_master_window_assertions

bind mwbt_master_window mwbt_master_window_assertions u_chk (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_ctrl_we(i_ctrl_we), .i_ctrl_wdata(i_ctrl_wdata),
  .i_page_we(i_page_we), .i_page_wdata(i_page_wdata), .i_stat_rd(i_stat_rd), .i_stat_clr(i_stat_clr),
  .i_irq_en(i_irq_en), .o_board_status_reg(o_board_status_reg), .o_host_irq(o_host_irq),
  .i_host_req(i_host_req), .i_host_addr(i_host_addr), .o_host_ready(o_host_ready),
  .o_host_abort(o_host_abort), .o_rem_cyc(o_rem_cyc), .o_rem_am(o_rem_am), .o_rem_addr(o_rem_addr));

/* File: mwbt_rem_slave_model.sv */
// Purpose: Remote slave answering translated cycles after a set delay
// Assumes: Delay of all ones holds the ack off far past the host limit
// Notes:   Read data toggles when released so stale data never looks valid
`timescale 1ns/100ps
module mwbt_rem_slave_model
  import mwbt_pkg::*;
(
  // Clock and remote cycle
  input  wire logic               i_clk,
  input  wire logic               i_cyc,
  input  wire logic [RADDR_W-1:0] i_addr,
  input  wire logic [15:0]        i_delay,
  // Answer
  output logic                    o_ack,
  output logic [DATA_W-1:0]       o_rdata = 16'h0000
);
  logic [15:0] wait_q = 16'h0000;

  // Ack after the delay, held until the cycle ends
  always_ff @(posedge i_clk) begin
    if (!i_cyc) begin
      wait_q  <= 16'h0000;
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
    end else if (wait_q == i_delay) begin
      o_ack   <= 1'b1;
      o_rdata <= i_addr[15:0] ^ 16'h5a5a;
    end else begin
      wait_q <= wait_q + 16'h0001;
    end
  end
endmodule : mwbt_rem_slave_model

/* File: mwbt_master_window_bench.sv */
// Purpose: Self-checking bench for the master window translator
// Assumes: Remote slave model on the far side, inbound collisions from the bench
// Notes:   Expected addresses and data are worked out from window settings
`timescale 1ns/100ps
module mwbt_master_window_bench;
  import mwbt_pkg::*;
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR %0t: value %h expected %h", $time, got, exp); end end

  logic                clk, rst_n, ctrl_we, page_we, stat_rd, stat_clr, host_req, host_wr;
  logic                host_ready, host_abort, host_irq, rem_cyc, rem_wr, rem_ack, inbound;
  logic [CTRL_W-1:0]   ctrl_wdata;
  logic [PAGE_W-1:0]   page_wdata;
  logic [STAT_W-1:0]   irq_en, stat;
  logic [HADDR_W-1:0]  host_addr;
  logic [DATA_W-1:0]   host_wdata, host_rdata, rem_wdata, rem_rdata;
  logic [AM_W-1:0]     rem_am;
  logic [RADDR_W-1:0]  rem_addr;
  logic [15:0]         dly;
  int                  error_cnt = 0;
  int                  samples_checked = 0;

  mwbt_master_window u_dut (.i_sys_clk(clk), .i_resetn(rst_n), .i_ctrl_we(ctrl_we),
    .i_ctrl_wdata(ctrl_wdata), .i_page_we(page_we), .i_page_wdata(page_wdata),
    .i_stat_rd(stat_rd), .i_stat_clr(stat_clr), .i_irq_en(irq_en), .o_board_status_reg(stat),
    .o_host_irq(host_irq), .i_host_req(host_req), .i_host_wr(host_wr), .i_host_addr(host_addr),
    .i_host_wdata(host_wdata), .o_host_ready(host_ready), .o_host_abort(host_abort),
    .o_host_rdata(host_rdata), .o_rem_cyc(rem_cyc), .o_rem_wr(rem_wr), .o_rem_am(rem_am),
    .o_rem_addr(rem_addr), .o_rem_wdata(rem_wdata), .i_rem_ack(rem_ack),
    .i_rem_rdata(rem_rdata), .i_rem_inbound(inbound));

  mwbt_rem_slave_model u_rem (.i_clk(clk), .i_cyc(rem_cyc), .i_addr(rem_addr), .i_delay(dly),
    .o_ack(rem_ack), .o_rdata(rem_rdata));

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Control and page written together, one cycle
  task automatic cfg(input logic en, input logic [4:0] am, input logic [15:0] pg);
    ctrl_we    = 1'b1;
    page_we    = 1'b1;
    ctrl_wdata = {am, 8'h00, 8'h0d, 7'h00, en};
    page_wdata = pg;
    step(1);
    ctrl_we = 1'b0;
    page_we = 1'b0;
  endtask : cfg

  // One host cycle; req holds until ready, then a gap for the ack to settle
  task automatic acc(input logic wr, input logic [23:0] a, input logic hit, input logic ab,
                     input logic [31:0] ea, input logic [31:0] m, input logic [4:0] eam);
    logic [31:0] ra;
    logic [4:0]  ram;
    logic [15:0] rwd;
    logic        rww;
    int          n;
    host_req   = 1'b1;
    host_wr    = wr;
    host_addr  = a;
    host_wdata = a[15:0] ^ 16'h0f0f;
    n = 0;
    while (host_ready !== 1'b1 && n < (hit ? 4000 : 20)) begin
      step(1);
      n++;
      if (rem_cyc === 1'b1) begin
        ra  = rem_addr;
        ram = rem_am;
        rwd = rem_wdata;
        rww = rem_wr;
      end
    end
    `CHK(host_ready, hit)
    if (hit) begin
      `CHK(host_abort, ab)
      `CHK(ram, eam)
      `CHK(rww, wr)
      `CHK(ra & m, ea & m)
      if (!ab && !wr) `CHK(host_rdata, ea[15:0] ^ 16'h5a5a)
      if (!ab && wr) `CHK(rwd, host_wdata)
    end
    host_req = 1'b0;
    step(6);
  endtask : acc

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Hang guard, well past one timeout run
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run;
  end

  initial begin
    {rst_n, ctrl_we, page_we, stat_rd, stat_clr, host_req, host_wr, inbound} = '0;
    {ctrl_wdata, page_wdata, irq_en, host_addr, host_wdata, dly} = '0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step(3);
    cfg(1'b0, 5'h11, 16'h0000);
    acc(1'b0, 24'hd4321, 1'b0, 1'b0, 32'h0, 32'h0, 5'h0);
    cfg(1'b1, 5'h11, 16'h5555);
    acc(1'b0, 24'hd4321, 1'b1, 1'b0, 32'h00004321, 32'hffffffff, 5'h11);
    acc(1'b0, 24'he4321, 1'b0, 1'b0, 32'h0, 32'h0, 5'h0);
    cfg(1'b1, 5'h19, 16'h0012);
    acc(1'b1, 24'hd3456, 1'b1, 1'b0, 32'h00123456, 32'hffffffff, 5'h19);
    cfg(1'b1, 5'h01, 16'h8765);
    dly = 16'd20;
    acc(1'b0, 24'hd4321, 1'b1, 1'b0, 32'h87654321, 32'hffffffff, 5'h01);
    acc(1'b0, 24'hd0000, 1'b1, 1'b0, 32'h87650000, 32'hffffffff, 5'h01);
    // Collision while the slave stalls
    dly    = 16'hffff;
    irq_en = 2'b01;
    fork
      acc(1'b1, 24'hd0010, 1'b1, 1'b1, 32'h87650010, 32'hffffffff, 5'h01);
      begin
        wait (rem_cyc === 1'b1);
        step(3);
        inbound = 1'b1;
        wait (host_ready === 1'b1);
        step(1);
        inbound = 1'b0;
      end
    join
    `CHK(stat, 2'b01)
    `CHK(host_irq, 1'b1)
    stat_rd = 1'b1;
    step(1);
    stat_rd = 1'b0;
    step(2);
    `CHK(stat, 2'b00)
    `CHK(host_irq, 1'b0)
    dly = 16'd0;
    acc(1'b1, 24'hd0010, 1'b1, 1'b0, 32'h87650010, 32'hffffffff, 5'h01);
    // Slave never answers: host limit ends the cycle
    dly    = 16'hffff;
    irq_en = 2'b10;
    acc(1'b0, 24'hd0020, 1'b1, 1'b1, 32'h87650020, 32'hffffffff, 5'h01);
    `CHK(stat, 2'b10)
    `CHK(host_irq, 1'b1)
    stat_clr = 1'b1;
    step(1);
    stat_clr = 1'b0;
    step(2);
    `CHK(stat, 2'b00)
    `CHK(host_irq, 1'b0)
    complete_run;
  end
endmodule : mwbt_master_window_bench
